// *** logic/ssbc_pkg.sv ***
// ssbc_pkg: constants, types and register map of the servo stop and brake control block
// assumes a 125 MHz clock and a classic wishbone register slave with 32-bit data
//
// Summary of operation
// - servo off on command, alarm or power loss
// - mode 0: dynamic brake stops and holds
// - mode 1: dynamic brake stops, then coasts
// - coast mode: drive off, no dynamic brake
// - hold mode at standstill or crawl: coast
// - both powers off: dynamic brake always
// - interlock low releases, high applies brake
// - routing 0 off, 1..3 pick slot
// - slot output is or of routed signals
// - sequencing select 0 enables, 1 disables
// - sequencing off ignores delay, level, timeout
// - stopped: servo off delayed 10 ms units
// - moving: brake at low speed or timeout
package ssbc_pkg;
  // register byte addresses
  localparam logic [7:0] SSBC_ADR_STOP_CFG  = 8'h00; // stop_function_config
  localparam logic [7:0] SSBC_ADR_OUT_SEL   = 8'h04; // output_selection_word_two
  localparam logic [7:0] SSBC_ADR_BRK_CFG   = 8'h08; // brake_sequence_config
  localparam logic [7:0] SSBC_ADR_DELAY     = 8'h0c; // brake_to_servo_off_delay
  localparam logic [7:0] SSBC_ADR_SPD_LVL   = 8'h10; // brake_speed_level
  localparam logic [7:0] SSBC_ADR_TIMEOUT   = 8'h14; // brake_output_timeout
  localparam logic [7:0] SSBC_ADR_OTHER_SEL = 8'h18; // routing of other slot signals
  localparam logic [7:0] SSBC_ADR_STATUS    = 8'h1c; // read-only state
  // reset values
  localparam logic [15:0] SSBC_RST_STOP_CFG = 16'h0000;
  localparam logic [15:0] SSBC_RST_OUT_SEL  = 16'h0000;
  localparam logic [15:0] SSBC_RST_BRK_CFG  = 16'h0000;
  localparam logic [15:0] SSBC_RST_DELAY    = 16'h0000;
  localparam logic [15:0] SSBC_RST_SPD_LVL  = 16'h0064; // 100 per minute
  localparam logic [15:0] SSBC_RST_TIMEOUT  = 16'h0032; // 50 x 10 ms
  // field positions
  localparam int SSBC_STOP_MODE_LSB = 0;  // stop_mode_select nibble
  localparam int SSBC_ROUTE_LSB     = 8;  // brake_output_routing nibble
  localparam int SSBC_SEQ_SEL_LSB   = 0;  // brake_sequencing_select nibble
  localparam int SSBC_DELAY_MAX     = 50; // largest delay setting
  // stop modes
  localparam logic [3:0] SSBC_MODE_DB_HOLD  = 4'h0;
  localparam logic [3:0] SSBC_MODE_DB_COAST = 4'h1;
  localparam logic [3:0] SSBC_MODE_COAST    = 4'h2;
  // slot numbers
  localparam int          SSBC_NUM_SLOTS = 3;
  localparam logic [31:0] SSBC_BAD_READ  = 32'h0000_0000;
  // timing: 10 ms tick at 125 MHz
  localparam int SSBC_CLK_MHZ    = 125;
  localparam int SSBC_TICK_US    = 10000;
  localparam int SSBC_TICK_CYC   = SSBC_TICK_US * SSBC_CLK_MHZ;
  localparam int SSBC_STOP_SPEED = 1; // speed at or below which the motor counts as stopped

  typedef enum logic [2:0] {
    SSBC_ST_RUN,     // servo on, brake released
    SSBC_ST_DELAY,   // brake applied, servo off pending
    SSBC_ST_DECEL,   // servo off while moving, brake waits
    SSBC_ST_OFF      // servo off, brake applied
  } ssbc_state_e;

  typedef struct packed {
    logic [15:0] stop_cfg;
    logic [15:0] out_sel;
    logic [15:0] brk_cfg;
    logic [15:0] delay;
    logic [15:0] spd_lvl;
    logic [15:0] timeout;
    logic [11:0] other_sel;
  } ssbc_cfg_s;

  typedef struct packed {
    logic servo_on;
    logic db_on;
    logic brake_release;
  } ssbc_drive_s;
endpackage

// *** logic/ssbc_tick.sv ***
// ssbc_tick: free 10 ms tick generator with a restart input
// assumes clk_i at the package rate
`timescale 1ns/1ps
module ssbc_tick (
  input  wire logic clk_i,   // system clock
  input  wire logic rst_i,   // synchronous reset, high
  input  wire logic clear_i, // restart the period
  output logic      tick_o   // one-cycle pulse each period
);
  import ssbc_pkg::*;
  localparam int          CW    = $clog2(SSBC_TICK_CYC);
  localparam logic [CW-1:0] LAST = CW'(SSBC_TICK_CYC - 1);
  logic [CW-1:0] cnt; // cycles in this period

  // period counter
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i || cnt == LAST) begin
      cnt <= '0;
    end else begin
      cnt <= cnt + 1'b1;
    end
  end

  // pulse at end of period
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= !clear_i && cnt == LAST;
    end
  end
endmodule

// *** logic/ssbc_top.sv ***
// ssbc_top: stop mode, dynamic brake and holding brake interlock logic with wishbone registers
// assumes pin inputs asynchronous to clk_i, motor speed from same-clock logic
//
// The implementer's own choices: register access over Wishbone and the address map.
`timescale 1ns/1ps
module ssbc_top (
  input  wire logic        clk_i,          // system clock
  input  wire logic        rst_i,          // synchronous reset, high
  input  wire logic        wb_cyc_i,       // wishbone cycle
  input  wire logic        wb_stb_i,       // wishbone strobe
  input  wire logic        wb_we_i,        // wishbone write
  input  wire logic [7:0]  wb_adr_i,       // wishbone byte address
  input  wire logic [3:0]  wb_sel_i,       // wishbone byte lanes
  input  wire logic [31:0] wb_dat_i,       // wishbone write data
  output logic      [31:0] wb_dat_o,       // wishbone read data
  output logic             wb_ack_o,       // wishbone acknowledge
  input  wire logic        servo_enable_i, // servo_enable_command level, pin
  input  wire logic        alarm_i,        // servo alarm level, pin
  input  wire logic        main_power_i,   // main power present, pin
  input  wire logic        ctrl_power_i,   // control power present, pin
  input  wire logic [15:0] motor_speed_i,  // absolute speed per minute
  input  wire logic [2:0]  other_status_i, // other status signals for the slots
  output logic             servo_on_o,     // motor drive enabled
  output logic             dyn_brake_o,    // dynamic_braking engaged
  output logic [2:0]       out_slot_n_o    // output_slot_one..three, low = on
);
  import ssbc_pkg::*;

  ssbc_cfg_s   cfg;        // software settings
  ssbc_state_e state;      // stop sequence state
  ssbc_drive_s drv;        // next output set
  logic [2:0]  en_s1;      // first synchroniser stage
  logic [2:0]  en_s2;      // synchronised pins
  logic [1:0]  pw_s1;      // first stage for power pins
  logic [1:0]  pw_s2;      // synchronised power pins
  logic        enable_req; // servo_enable_command seen
  logic        stop_req;   // any stop cause
  logic        power_gone; // both powers off
  logic        stopped;    // motor at rest or crawling
  logic        seq_on;     // parameter brake timing in use
  logic [3:0]  mode;       // stop_mode_select
  logic [3:0]  route;      // brake_output_routing
  logic [15:0] tcount;     // 10 ms ticks in this state
  logic        tick;       // 10 ms pulse
  logic        tclear;     // restart tick on state change
  logic        brake_on;   // holding brake interlock active
  logic [31:0] rdata;      // decoded read word
  logic        req;        // bus request this cycle

  // slot decode: one-hot for routing nibble, used for every routed signal
  function automatic logic [2:0] slot_dec(input logic [3:0] r);
    logic [2:0] v;
    v = 3'h0;
    if (r >= 4'h1 && r <= 4'h3) begin
      v[r[1:0] - 2'h1] = 1'b1;
    end
    return v;
  endfunction

  // two-flop synchronisers for pins
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_s1 <= 3'h0;
      en_s2 <= 3'h0;
      // power counts as present until synced, so no false dynamic brake after reset
      pw_s1 <= 2'h3;
      pw_s2 <= 2'h3;
    end else begin
      en_s1 <= {servo_enable_i, alarm_i, 1'b0};
      en_s2 <= en_s1;
      pw_s1 <= {main_power_i, ctrl_power_i};
      pw_s2 <= pw_s1;
    end
  end

  assign enable_req = en_s2[2];
  assign power_gone = !pw_s2[1] && !pw_s2[0];
  assign stop_req   = !enable_req || en_s2[1] || !pw_s2[1] || !pw_s2[0];
  assign stopped    = motor_speed_i <= 16'(SSBC_STOP_SPEED);
  assign seq_on     = cfg.brk_cfg[SSBC_SEQ_SEL_LSB +: 4] == 4'h0;
  assign mode       = cfg.stop_cfg[SSBC_STOP_MODE_LSB +: 4];
  assign route      = cfg.out_sel[SSBC_ROUTE_LSB +: 4];
  assign req        = wb_cyc_i && wb_stb_i && !wb_ack_o;

  ssbc_tick u_tick (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (tclear),
    .tick_o  (tick)
  );

  // register writes
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cfg.stop_cfg  <= SSBC_RST_STOP_CFG;
      cfg.out_sel   <= SSBC_RST_OUT_SEL;
      cfg.brk_cfg   <= SSBC_RST_BRK_CFG;
      cfg.delay     <= SSBC_RST_DELAY;
      cfg.spd_lvl   <= SSBC_RST_SPD_LVL;
      cfg.timeout   <= SSBC_RST_TIMEOUT;
      cfg.other_sel <= 12'h000;
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i) begin // write lands at the ack edge
      unique case (wb_adr_i)
        SSBC_ADR_STOP_CFG: begin
          if (wb_sel_i[0]) cfg.stop_cfg[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) cfg.stop_cfg[15:8] <= wb_dat_i[15:8];
        end
        SSBC_ADR_OUT_SEL: begin
          if (wb_sel_i[0]) cfg.out_sel[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) cfg.out_sel[15:8] <= wb_dat_i[15:8];
        end
        SSBC_ADR_BRK_CFG: begin
          if (wb_sel_i[0]) cfg.brk_cfg[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) cfg.brk_cfg[15:8] <= wb_dat_i[15:8];
        end
        SSBC_ADR_DELAY: begin
          // clamp to the settable range
          if (wb_sel_i[0] && wb_sel_i[1]) begin
            cfg.delay <= (wb_dat_i[15:0] > 16'(SSBC_DELAY_MAX)) ? 16'(SSBC_DELAY_MAX) : wb_dat_i[15:0];
          end
        end
        SSBC_ADR_SPD_LVL: begin
          if (wb_sel_i[0]) cfg.spd_lvl[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) cfg.spd_lvl[15:8] <= wb_dat_i[15:8];
        end
        SSBC_ADR_TIMEOUT: begin
          if (wb_sel_i[0]) cfg.timeout[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) cfg.timeout[15:8] <= wb_dat_i[15:8];
        end
        SSBC_ADR_OTHER_SEL: begin
          if (wb_sel_i[0]) cfg.other_sel[7:0]  <= wb_dat_i[7:0];
          if (wb_sel_i[1]) cfg.other_sel[11:8] <= wb_dat_i[11:8];
        end
        default: begin
          // read-only or unmapped: write ignored
        end
      endcase
    end
  end

  // read mux
  always_comb begin
    unique case (wb_adr_i)
      SSBC_ADR_STOP_CFG:  rdata = {16'h0000, cfg.stop_cfg};
      SSBC_ADR_OUT_SEL:   rdata = {16'h0000, cfg.out_sel};
      SSBC_ADR_BRK_CFG:   rdata = {16'h0000, cfg.brk_cfg};
      SSBC_ADR_DELAY:     rdata = {16'h0000, cfg.delay};
      SSBC_ADR_SPD_LVL:   rdata = {16'h0000, cfg.spd_lvl};
      SSBC_ADR_TIMEOUT:   rdata = {16'h0000, cfg.timeout};
      SSBC_ADR_OTHER_SEL: rdata = {20'h00000, cfg.other_sel};
      SSBC_ADR_STATUS:    rdata = {24'h000000, 1'b0, brake_on, dyn_brake_o, servo_on_o,
                                   1'b0, 3'(state)};
      default:            rdata = SSBC_BAD_READ;
    endcase
  end

  // bus answer: ack one cycle after request, dropped next cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req;
      wb_dat_o <= req ? rdata : 32'h0000_0000;
    end
  end

  // stop sequence state and 10 ms counter
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state  <= SSBC_ST_OFF;
      tcount <= 16'h0000;
    end else begin
      unique case (state)
        SSBC_ST_RUN: begin
          if (stop_req && (en_s2[1] || power_gone)) begin
            state <= SSBC_ST_OFF; // alarm or both powers off: off at once
          end else if (stop_req && !seq_on) begin
            state <= SSBC_ST_OFF;
          end else if (stop_req && stopped) begin
            state <= (cfg.delay == 16'h0000) ? SSBC_ST_OFF : SSBC_ST_DELAY;
          end else if (stop_req) begin
            state <= SSBC_ST_DECEL;
          end
        end
        SSBC_ST_DELAY: begin
          if (tcount >= cfg.delay || en_s2[1] || power_gone) begin
            state <= SSBC_ST_OFF;
          end
        end
        SSBC_ST_DECEL: begin
          if (motor_speed_i < cfg.spd_lvl || tcount >= cfg.timeout) begin
            state <= SSBC_ST_OFF;
          end
        end
        SSBC_ST_OFF: begin
          if (!stop_req) begin
            state <= SSBC_ST_RUN;
          end
        end
      endcase
      tcount <= tclear ? 16'h0000 : (tick ? tcount + 16'h0001 : tcount);
    end
  end

  // restart tick on leaving the run state
  assign tclear = state == SSBC_ST_RUN || state == SSBC_ST_OFF;

  // drive, dynamic brake and holding brake decisions
  always_comb begin
    drv.servo_on      = state == SSBC_ST_RUN || state == SSBC_ST_DELAY;
    drv.brake_release = state == SSBC_ST_RUN;
    drv.db_on         = 1'b0;
    // servo is off while decelerating too, so the stop mode applies there
    if (state == SSBC_ST_OFF || state == SSBC_ST_DECEL) begin
      if (power_gone) begin
        drv.db_on = 1'b1;
      end else if (mode == SSBC_MODE_DB_HOLD) begin
        drv.db_on = !(stopped && !dyn_brake_o);
      end else if (mode == SSBC_MODE_DB_COAST) begin
        drv.db_on = !stopped;
      end else begin
        drv.db_on = 1'b0;
      end
    end
    // interlock: applied during the delay, released while decelerating
    if (state == SSBC_ST_DELAY || state == SSBC_ST_DECEL) begin
      drv.brake_release = state == SSBC_ST_DECEL;
    end
  end

  assign brake_on = !drv.brake_release;

  // registered motor outputs and slots
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      servo_on_o   <= 1'b0;
      dyn_brake_o  <= 1'b0;
      out_slot_n_o <= 3'h7;
    end else begin
      servo_on_o   <= drv.servo_on;
      dyn_brake_o  <= drv.db_on;
      // brake interlock is active-low on the slot: on = release
      out_slot_n_o <= ~((drv.brake_release ? slot_dec(route) : 3'h0) |
                        (other_status_i[0] ? slot_dec(cfg.other_sel[3:0]) : 3'h0) |
                        (other_status_i[1] ? slot_dec(cfg.other_sel[7:4]) : 3'h0) |
                        (other_status_i[2] ? slot_dec(cfg.other_sel[11:8]) : 3'h0));
    end
  end

  // checks
  a_alarm_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == SSBC_ST_RUN && en_s2[1]) |=> ##1 !servo_on_o)
    else $error("alarm did not turn servo off");
  a_power_db: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == SSBC_ST_OFF && power_gone) |=> dyn_brake_o)
    else $error("no dynamic brake after power loss");
  a_coast_nodb: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == SSBC_ST_OFF && !power_gone && mode == SSBC_MODE_COAST) |=> !dyn_brake_o)
    else $error("coast mode engaged dynamic brake");
  a_coast_after: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == SSBC_ST_OFF && !power_gone && mode == SSBC_MODE_DB_COAST && stopped) |=> !dyn_brake_o)
    else $error("dynamic brake not released at rest");
  a_hold_moving: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == SSBC_ST_OFF && mode == SSBC_MODE_DB_HOLD && !stopped) |=> dyn_brake_o)
    else $error("hold mode without dynamic brake");
  a_hold_slow: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == SSBC_ST_OFF && !power_gone && mode == SSBC_MODE_DB_HOLD && stopped && !dyn_brake_o)
    |=> !dyn_brake_o)
    else $error("dynamic brake on a stopped motor");
  a_seq_skip: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == SSBC_ST_RUN && stop_req && !seq_on) |=> state == SSBC_ST_OFF)
    else $error("sequencing disabled yet delayed");
  a_route_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (route == 4'h0 && cfg.other_sel == 12'h000) |=> out_slot_n_o == 3'h7)
    else $error("disabled routing drove a slot");
  a_brake_slot: assert property (@(posedge clk_i) disable iff (rst_i)
    (route == 4'h2 && drv.brake_release) |=> !out_slot_n_o[1])
    else $error("brake release not low on slot two");
  a_slot_or: assert property (@(posedge clk_i) disable iff (rst_i)
    (cfg.other_sel[3:0] == 4'h1 && other_status_i[0]) |=> !out_slot_n_o[0])
    else $error("slot not or of routed signals");
  a_delay_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == SSBC_ST_DELAY && tcount < cfg.delay && !en_s2[1] && !power_gone) |=> state == SSBC_ST_DELAY)
    else $error("servo off before brake delay");
  a_decel_end: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == SSBC_ST_DECEL && motor_speed_i < cfg.spd_lvl) |=> state == SSBC_ST_OFF)
    else $error("brake not applied below speed level");
  a_seq_sel: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == SSBC_ST_RUN && !seq_on) |=> (state == SSBC_ST_RUN || state == SSBC_ST_OFF))
    else $error("sequencing select misread");
  a_decel_off: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == SSBC_ST_DECEL) |=> !servo_on_o)
    else $error("drive left on while decelerating");
  a_mode_reserved: assert property (@(posedge clk_i) disable iff (rst_i)
    (state == SSBC_ST_OFF && !power_gone && mode > SSBC_MODE_DB_COAST) |=> !dyn_brake_o)
    else $error("reserved mode engaged brake");
  c_decel: cover property (@(posedge clk_i) state == SSBC_ST_DECEL ##1 state == SSBC_ST_OFF);
  c_delay: cover property (@(posedge clk_i) state == SSBC_ST_DELAY ##1 state == SSBC_ST_OFF);
  c_run:   cover property (@(posedge clk_i) state == SSBC_ST_OFF ##1 state == SSBC_ST_RUN);
endmodule

// *** tb/ssbc_host_model.sv ***
// ssbc_host_model: host controller sequencing enable, brake supply and speed, plus brake relay
// assumes clk_i shared with the device; long waits scaled down to cycles
`timescale 1ns/1ps
module ssbc_host_model #(
  parameter int REF_WAIT = 16, // cycles from brake supply to first speed reference
  parameter int OFF_WAIT = 8,  // cycles from brake supply off to enable off
  parameter int STEP     = 50  // speed change per cycle
) (
  input  wire logic        clk_i,       // system clock
  input  wire logic        rst_i,       // reset, high
  input  wire logic        run_i,       // bench wants the servo on
  input  wire logic        quick_i,     // drop enable at once on stop
  input  wire logic [15:0] speed_cmd_i, // wanted speed
  input  wire logic        servo_on_i,  // device drive state
  input  wire logic        brk_n_i,     // interlock slot, low = release
  output logic             enable_o,    // servo enable pin
  output logic [15:0]      speed_o,     // motor speed
  output logic             held_o       // holding brake engaged
);
  logic        brk_pwr; // holding brake supply on
  int          t_on;    // cycles since supply on
  int          t_off;   // cycles since supply off
  logic [15:0] tgt;     // speed the motor heads for
  // relay open or no supply: brake holds
  assign held_o = brk_n_i | ~brk_pwr;
  // no reference before the supply wait ran out
  assign tgt = (servo_on_i && t_on >= REF_WAIT) ? speed_cmd_i : 16'h0000;
  // supply timers
  always_ff @(posedge clk_i) begin
    t_on  <= (rst_i || !brk_pwr) ? 0 : ((t_on < REF_WAIT) ? t_on + 1 : t_on);
    t_off <= (rst_i || brk_pwr) ? 0 : ((t_off < OFF_WAIT) ? t_off + 1 : t_off);
  end
  // enable and supply sequencing
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      enable_o <= 1'b0;
      brk_pwr  <= 1'b0;
    end else if (run_i) begin
      enable_o <= 1'b1;
      brk_pwr  <= 1'b1;
    end else begin
      if (quick_i)
        enable_o <= 1'b0;
      if (speed_o == 16'h0000)
        brk_pwr <= 1'b0;
      if (!brk_pwr && t_off >= OFF_WAIT)
        enable_o <= 1'b0;
    end
  end
  // motor speed ramps toward target, friction when off
  always_ff @(posedge clk_i) begin
    if (rst_i)
      speed_o <= 16'h0000;
    else if (32'(speed_o) > 32'(tgt) + STEP)
      speed_o <= speed_o - 16'(STEP);
    else if (32'(speed_o) + STEP < 32'(tgt))
      speed_o <= speed_o + 16'(STEP);
    else
      speed_o <= tgt;
  end
endmodule

// *** tb/tb_top.sv ***
// tb_top: scenario bench for the stop and brake control block
// assumes ssbc_pkg, ssbc_top and the host model are compiled first
`timescale 1ns/1ps
module tb_top;
  import ssbc_pkg::*;
  logic        clk_i = 1'b0;     // 125 MHz clock
  logic        rst_i = 1'b1;     // reset
  logic        wb_cyc = 1'b0;    // bus cycle
  logic        wb_stb = 1'b0;    // bus strobe
  logic        wb_we = 1'b0;     // bus write
  logic [7:0]  wb_adr = 8'h00;   // bus address
  logic [3:0]  wb_sel = 4'h0;    // bus lanes
  logic [31:0] wb_wd = 32'h0;    // bus write data
  logic [31:0] wb_rd;            // bus read data
  logic        wb_ack;           // bus ack
  logic        alarm = 1'b0;     // alarm pin
  logic        main_pwr = 1'b1;  // main power pin
  logic        ctrl_pwr = 1'b1;  // control power pin
  logic [2:0]  other = 3'h0;     // other status
  logic        run = 1'b0;       // host run request
  logic        quick = 1'b0;     // host quick stop
  logic [15:0] spd_cmd = 16'h0;  // host speed wish
  logic        enable;           // servo enable pin
  logic [15:0] speed;            // motor speed
  logic        servo_on;         // drive on
  logic        dyn_brk;          // dynamic brake
  logic [2:0]  slot_n;           // output slots
  int          mismatches = 0;   // failed compares
  int          n_tests = 0;      // compares made
  always #4 clk_i = ~clk_i;
  ssbc_top dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_wd), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack),
    .servo_enable_i(enable), .alarm_i(alarm), .main_power_i(main_pwr), .ctrl_power_i(ctrl_pwr),
    .motor_speed_i(speed), .other_status_i(other), .servo_on_o(servo_on), .dyn_brake_o(dyn_brk),
    .out_slot_n_o(slot_n));
  // host watches slot two, the usual brake slot
  ssbc_host_model host (.clk_i(clk_i), .rst_i(rst_i), .run_i(run), .quick_i(quick),
    .speed_cmd_i(spd_cmd), .servo_on_i(servo_on), .brk_n_i(slot_n[1]), .enable_o(enable),
    .speed_o(speed), .held_o());
  // compare and count
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one classic bus cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc <= 1'b1;
    wb_stb <= 1'b1;
    wb_we  <= we;
    wb_adr <= a;
    wb_sel <= 4'hf;
    wb_wd  <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack !== 1'b1 && n < 50);
    chk("bus ack", 32'(wb_ack), 32'h1);
    q = wb_rd;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(nm, q, e);
  endtask
  task automatic settle();
    repeat (8) @(posedge clk_i);
  endtask
  // bounded waits on drive state and speed
  task automatic wait_on(input logic v);
    int n;
    n = 0;
    while (servo_on !== v && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk("servo on wait", 32'(servo_on), 32'(v));
  endtask
  task automatic wait_spd(input logic [15:0] s);
    int n;
    n = 0;
    while (speed !== s && n < 200) begin
      @(posedge clk_i);
      n++;
    end
    chk("speed wait", 32'(speed), 32'(s));
  endtask
  task automatic start(input logic [15:0] s);
    spd_cmd <= s;
    quick   <= 1'b0;
    run     <= 1'b1;
    wait_on(1'b1);
    wait_spd(s);
  endtask
  task automatic stop_quick();
    quick <= 1'b1;
    run   <= 1'b0;
    settle();
  endtask
  // reset values, unmapped place, delay clamp
  task automatic t_regs();
    chk("reset slots", 32'(slot_n), 32'h7);
    chk("reset drive", 32'(servo_on), 32'h0);
    rd_chk("stop cfg", SSBC_ADR_STOP_CFG, {16'h0, SSBC_RST_STOP_CFG});
    rd_chk("out sel", SSBC_ADR_OUT_SEL, {16'h0, SSBC_RST_OUT_SEL});
    rd_chk("brk cfg", SSBC_ADR_BRK_CFG, {16'h0, SSBC_RST_BRK_CFG});
    rd_chk("delay", SSBC_ADR_DELAY, {16'h0, SSBC_RST_DELAY});
    rd_chk("spd lvl", SSBC_ADR_SPD_LVL, {16'h0, SSBC_RST_SPD_LVL});
    rd_chk("timeout", SSBC_ADR_TIMEOUT, {16'h0, SSBC_RST_TIMEOUT});
    wr(8'h20, 32'h0000_1234);
    rd_chk("unmapped", 8'h20, SSBC_BAD_READ);
    wr(SSBC_ADR_DELAY, 32'h0000_0063);
    rd_chk("delay clamp", SSBC_ADR_DELAY, 32'(SSBC_DELAY_MAX));
    wr(SSBC_ADR_DELAY, 32'h0);
    $display("done registers");
  endtask
  // routing values 0 to 3, release then orderly stop
  task automatic t_route();
    for (int r = 0; r < 4; r++) begin
      wr(SSBC_ADR_OUT_SEL, 32'(r) << 8);
      start(16'h0000);
      chk("slot released", 32'(slot_n), (r == 0) ? 32'h7 : 32'(3'h7 & ~(3'h1 << (r - 1))));
      run <= 1'b0;
      wait_on(1'b0);
      settle();
      chk("slot applied", 32'(slot_n), 32'h7);
    end
    $display("done routing");
  endtask
  // brake and other status share slot two
  task automatic t_or();
    wr(SSBC_ADR_OTHER_SEL, 32'h2);
    other <= 3'h1;
    settle();
    chk("or slot", 32'(slot_n), 32'h5);
    other <= 3'h0;
    settle();
    chk("or slot idle", 32'(slot_n), 32'h7);
    wr(SSBC_ADR_OTHER_SEL, 32'h0);
    $display("done or");
  endtask
  // stop modes with sequencing off, then hold at rest
  task automatic t_modes();
    wr(SSBC_ADR_BRK_CFG, 32'h1);
    for (int m = 0; m < 3; m++) begin
      wr(SSBC_ADR_STOP_CFG, 32'(m));
      start(16'd500);
      stop_quick();
      chk("drive off moving", 32'(servo_on), 32'h0);
      chk("brake at once", 32'(slot_n[1]), 32'h1);
      chk("db moving", 32'(dyn_brk), 32'(m != 2));
      wait_spd(16'h0000);
      settle();
      chk("db at rest", 32'(dyn_brk), 32'(m == 0));
    end
    wr(SSBC_ADR_STOP_CFG, 32'h0);
    start(16'h0000);
    stop_quick();
    chk("db hold from rest", 32'(dyn_brk), 32'h0);
    $display("done modes");
  endtask
  // power loss in coast mode
  task automatic t_power();
    wr(SSBC_ADR_STOP_CFG, 32'h2);
    start(16'd500);
    main_pwr <= 1'b0;
    settle();
    chk("drive off power", 32'(servo_on), 32'h0);
    stop_quick();
    wait_spd(16'h0000);
    ctrl_pwr <= 1'b0;
    settle();
    chk("db both off", 32'(dyn_brk), 32'h1);
    main_pwr <= 1'b1;
    ctrl_pwr <= 1'b1;
    settle();
    chk("db powers back", 32'(dyn_brk), 32'h0);
    $display("done power");
  endtask
  // alarm with sequencing on, then speed level path
  task automatic t_alarm_decel();
    wr(SSBC_ADR_BRK_CFG, 32'h0);
    wr(SSBC_ADR_STOP_CFG, 32'h1);
    start(16'd500);
    alarm <= 1'b1;
    settle();
    chk("drive off alarm", 32'(servo_on), 32'h0);
    stop_quick();
    alarm <= 1'b0;
    wait_spd(16'h0000);
    start(16'd500);
    stop_quick();
    chk("drive off decel", 32'(servo_on), 32'h0);
    chk("db decel", 32'(dyn_brk), 32'h1);
    chk("brake kept released", 32'(slot_n[1]), 32'h0);
    for (int n = 0; n < 200 && slot_n[1] !== 1'b1; n++) @(posedge clk_i);
    chk("slow at brake", 32'(speed < 16'd100), 32'h1);
    settle();
    chk("brake applied", 32'(slot_n[1]), 32'h1);
    $display("done decel");
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge clk_i);
    mismatches++;
    tally_and_finish();
  end
  // main sequence
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_regs();
    wr(SSBC_ADR_OUT_SEL, 32'h0000_0200);
    t_or();
    t_route();
    wr(SSBC_ADR_OUT_SEL, 32'h0000_0200);
    t_modes();
    t_power();
    t_alarm_decel();
    tally_and_finish();
  end
endmodule
